/* File: design/spe_regs.svh */
// Constants of the serial memory protocol front end and its APB map
`ifndef SPE_REGS_SVH
`define SPE_REGS_SVH

// Instruction opcodes
`define SPE_OP_ARM 8'h06
`define SPE_OP_DISARM 8'h04
`define SPE_OP_GET_STATUS 8'h05
`define SPE_OP_PUT_STATUS 8'h01
`define SPE_OP_ARR_READ 8'h03
`define SPE_OP_ARR_WRITE 8'h02
`define SPE_OP_GET_IDENT 8'h83
`define SPE_OP_PUT_IDENT 8'h82

// Status byte layout
`define SPE_SB_BUSY 0
`define SPE_SB_ARM 1
`define SPE_SB_PLO 2
`define SPE_SB_PHI 3
`define SPE_SB_LOCK 7

// Address bit that picks lock access on the ident opcodes
`define SPE_ID_LOCK_BIT 10
// Page writes, array and ident alike, wrap inside this many low address bits
`define SPE_PAGE_BITS 7

// Protected ranges per protect code
`define SPE_PROT_NONE 2'b00
`define SPE_PROT_QTR 2'b01
`define SPE_PROT_HALF 2'b10
`define SPE_PROT_QTR_BASE 16'hc000
`define SPE_PROT_HALF_BASE 16'h8000

// Bit counter value of the last bit of a byte
`define SPE_LAST_BIT 3'h7

// Commit kinds toward the array
`define SPE_CK_ARRAY 2'h0
`define SPE_CK_IDENT 2'h1
`define SPE_CK_IDLOCK 2'h2

// Write cycle time, in ns, and the pclk period in ns
`define SPE_TW_NS 5000000
`define SPE_PCLK_NS 25

// APB register byte offsets
`define SPE_R_STATUS 8'h00
`define SPE_R_WCYCLE 8'h04
`define SPE_R_LASTCMD 8'h08
`define SPE_R_ADDR 8'h0c

// Reset values of the control registers
`define SPE_RST_STATUS 8'h00
`define SPE_RST_BYTE 8'h00
`define SPE_RST_ADDR 16'h0000
`define SPE_RST_CNT 3'h0

`endif

/* File: design/spe_pkg.sv */
// Types shared by the serial memory protocol front end
package spe_pkg;
  // Protocol sequencer states
  typedef enum logic [3:0] {
    spe_st_opcode = 4'b0000,
    spe_st_addr_hi = 4'b0001,
    spe_st_addr_lo = 4'b0010,
    spe_st_wdata = 4'b0011,
    spe_st_rdout = 4'b0100,
    spe_st_sout = 4'b0101,
    spe_st_sin = 4'b0110,
    spe_st_armcmd = 4'b0111,
    spe_st_wait = 4'b1000
  } spe_state_type;

  // Decoded command kind
  typedef enum logic [2:0] {
    spe_k_none = 3'b000,
    spe_k_arr_rd = 3'b001,
    spe_k_arr_wr = 3'b010,
    spe_k_id_rd = 3'b011,
    spe_k_id_wr = 3'b100,
    spe_k_arm = 3'b101,
    spe_k_disarm = 3'b110,
    spe_k_stat_wr = 3'b111
  } spe_kind_type;
endpackage

/* File: design/spe_pin_sync.sv */
// Three-flop pin synchroniser with agreement filter
`timescale 1ns/1ps
module spe_pin_sync #(
  parameter logic RST = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  output logic level
);
  logic s1_ff; // First stage, read only by the second
  logic s2_ff;
  logic s3_ff;
  logic level_ff; // Accepted level

  // Shift chain; level moves only when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= RST;
      s2_ff <= RST;
      s3_ff <= RST;
      level_ff <= RST;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      if (s2_ff == s3_ff) begin
        level_ff <= s3_ff;
      end
    end
  end

  assign level = level_ff;
endmodule

/* File: design/spe_wcycle.sv */
// Self-timed internal write cycle timer
`timescale 1ns/1ps
module spe_wcycle (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic [19:0] len,
  output logic busy,
  output logic done
);
  logic [19:0] cnt_ff; // Cycles left
  logic busy_ff;
  logic done_ff; // One-cycle end pulse

  // Count down from the programmed length; a zero length still lasts one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= 20'h00000;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        busy_ff <= 1'b1;
        cnt_ff <= len;
      end else if (busy_ff) begin
        if (cnt_ff <= 20'h00001) begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 20'h00001;
        end
      end
    end
  end

  assign busy = busy_ff;
  assign done = done_ff;
endmodule

/* File: design/spe_ctrl.sv */
// Protocol front end of a serial byte-wide nonvolatile memory, APB slave
`timescale 1ns/1ps
`include "spe_regs.svh"
module spe_ctrl import spe_pkg::*; #(
  parameter int TW_CYCLES = `SPE_TW_NS / `SPE_PCLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic hold_n,
  input wire logic wp_n,
  output logic miso,
  output logic miso_oe,
  // Nonvolatile bits as stored, caught after reset
  input wire logic [2:0] nv_init,
  // Array side
  output logic [15:0] rd_addr,
  output logic rd_ident,
  input wire logic [7:0] rd_data,
  output logic stage_we,
  output logic [15:0] stage_addr,
  output logic [7:0] stage_data,
  output logic commit,
  output logic [1:0] commit_kind,
  output logic [15:0] commit_addr,
  output logic [2:0] nv_bits,
  output logic standby
);
  // Synchronised pin levels
  logic sck_s, cs_n_s, mosi_s, hold_n_s, wp_n_s;
  spe_pin_sync #(.RST(1'b0)) u_sck (.pclk(pclk), .presetn(presetn),
    .pin(sck), .level(sck_s));
  // Select starts low so a pin already low gives no falling edge
  spe_pin_sync #(.RST(1'b0)) u_cs (.pclk(pclk), .presetn(presetn),
    .pin(cs_n), .level(cs_n_s));
  spe_pin_sync #(.RST(1'b0)) u_mosi (.pclk(pclk), .presetn(presetn),
    .pin(mosi), .level(mosi_s));
  spe_pin_sync #(.RST(1'b1)) u_hold (.pclk(pclk), .presetn(presetn),
    .pin(hold_n), .level(hold_n_s));
  spe_pin_sync #(.RST(1'b1)) u_wp (.pclk(pclk), .presetn(presetn),
    .pin(wp_n), .level(wp_n_s));

  logic sck_prev_ff, cs_prev_ff; // Previous levels for edge finding
  logic armed_cs_ff; // A select falling edge has been seen
  logic sel_prev_ff;
  logic paused_ff;
  logic [2:0] bit_cnt_ff; // Bit position within a byte
  logic [7:0] rx_ff; // Receive shifter
  logic [7:0] tx_ff; // Transmit shifter
  logic miso_ff, oe_ff;
  spe_state_type state_ff;
  spe_kind_type kind_ff;
  logic [7:0] opcode_ff;
  logic [15:0] addr_ff; // Running address
  logic [15:0] cmd_addr_ff; // Start address of the command
  logic has_data_ff; // At least one whole data byte taken
  logic [7:0] sin_ff; // Status byte to write
  logic arm_ff; // Write arm latch
  logic [2:0] nv_ff; // {lock, protect hi, protect lo}
  logic nv_load_ff; // Catch stored bits once after reset
  logic pend_stat_ff; // Cycle running is a status write
  logic stage_we_ff, commit_ff;
  logic [15:0] stage_addr_ff, commit_addr_ff;
  logic [7:0] stage_data_ff;
  logic [1:0] commit_kind_ff;
  logic [19:0] wcycle_ff; // Programmed write cycle length
  logic [7:0] last_op_ff;
  logic last_ok_ff, last_ref_ff;
  logic [31:0] prdata_ff;
  logic pslverr_ff;

  logic selected, active, sck_rise, sck_fall, deselect, byte_done;
  logic [7:0] byte_val, status_byte;
  logic busy, wdone, start_w, launch_arr, refuse;
  logic whole, wp_lock;

  // Selection needs a seen falling edge first
  assign selected = armed_cs_ff && !cs_n_s;
  assign active = selected && !paused_ff;
  assign sck_rise = sck_s && !sck_prev_ff;
  assign sck_fall = !sck_s && sck_prev_ff;
  assign deselect = sel_prev_ff && !selected;
  assign byte_done = active && sck_rise && (bit_cnt_ff == `SPE_LAST_BIT);
  assign byte_val = {rx_ff[6:0], mosi_s};
  // Standby only when idle and no internal cycle running
  assign standby = !selected && !busy;
  assign whole = (bit_cnt_ff == `SPE_RST_CNT);
  assign wp_lock = nv_ff[2] && !wp_n_s;

  // Status byte as seen by a status read
  always_comb begin
    status_byte = `SPE_RST_STATUS;
    status_byte[`SPE_SB_BUSY] = busy;
    status_byte[`SPE_SB_ARM] = arm_ff;
    status_byte[`SPE_SB_PLO] = nv_ff[0];
    status_byte[`SPE_SB_PHI] = nv_ff[1];
    status_byte[`SPE_SB_LOCK] = nv_ff[2];
  end

  // Protect range decode on a start address
  function automatic logic prot_hit(input logic [1:0] bp,
                                    input logic [15:0] a);
    case (bp)
      `SPE_PROT_NONE: prot_hit = 1'b0;
      `SPE_PROT_QTR: prot_hit = (a >= `SPE_PROT_QTR_BASE);
      `SPE_PROT_HALF: prot_hit = (a >= `SPE_PROT_HALF_BASE);
      default: prot_hit = 1'b1; // Whole array
    endcase
  endfunction

  // Write launch at deselect; a paused deselect keeps only array and ident writes
  always_comb begin
    launch_arr = 1'b0;
    refuse = 1'b0;
    start_w = 1'b0;
    if (deselect) begin
      case (kind_ff)
        spe_k_arr_wr, spe_k_id_wr: begin
          if (has_data_ff) begin
            if (whole && arm_ff && !busy &&
                !(kind_ff == spe_k_arr_wr &&
                  prot_hit(nv_ff[1:0], cmd_addr_ff))) begin
              launch_arr = 1'b1;
              start_w = 1'b1;
            end else begin
              refuse = 1'b1;
            end
          end
        end
        spe_k_stat_wr: begin
          if (!paused_ff && whole && has_data_ff && arm_ff && !busy &&
              !wp_lock) begin
            start_w = 1'b1;
          end else begin
            refuse = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  spe_wcycle u_wcycle (.pclk(pclk), .presetn(presetn), .start(start_w),
    .len(wcycle_ff), .busy(busy), .done(wdone));

  // Edge history and selection qualification
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_ff <= 1'b0;
      cs_prev_ff <= 1'b0;
      armed_cs_ff <= 1'b0;
      sel_prev_ff <= 1'b0;
    end else begin
      sck_prev_ff <= sck_s;
      cs_prev_ff <= cs_n_s;
      sel_prev_ff <= selected;
      if (cs_prev_ff && !cs_n_s) begin
        armed_cs_ff <= 1'b1;
      end
    end
  end

  // Pause enters only while the serial clock is low; it leaves then too, or at deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused_ff <= 1'b0;
    end else if (!selected) begin
      paused_ff <= 1'b0; // Pause has no meaning when deselected
    end else if (!sck_s) begin
      paused_ff <= !hold_n_s;
    end
  end

  // Receive shifter and bit count; frozen while paused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_ff <= `SPE_RST_BYTE;
      bit_cnt_ff <= `SPE_RST_CNT;
    end else if (!selected && !deselect) begin
      bit_cnt_ff <= `SPE_RST_CNT;
    end else if (active && sck_rise) begin
      rx_ff <= byte_val;
      bit_cnt_ff <= bit_cnt_ff + 3'h1;
    end
  end

  // Command sequencer, byte by byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= spe_st_opcode;
      kind_ff <= spe_k_none;
      opcode_ff <= `SPE_RST_BYTE;
      addr_ff <= `SPE_RST_ADDR;
      cmd_addr_ff <= `SPE_RST_ADDR;
      has_data_ff <= 1'b0;
      sin_ff <= `SPE_RST_BYTE;
    end else if (deselect) begin
      // Deselect, paused or not, drops the command logic
      state_ff <= spe_st_opcode;
      kind_ff <= spe_k_none;
      has_data_ff <= 1'b0;
    end else if (byte_done) begin
      case (state_ff)
        spe_st_opcode: begin
          opcode_ff <= byte_val;
          case (byte_val)
            `SPE_OP_ARR_READ: begin
              kind_ff <= spe_k_arr_rd;
              state_ff <= spe_st_addr_hi;
            end
            `SPE_OP_ARR_WRITE: begin
              kind_ff <= spe_k_arr_wr;
              state_ff <= spe_st_addr_hi;
            end
            `SPE_OP_GET_IDENT: begin
              kind_ff <= spe_k_id_rd;
              state_ff <= spe_st_addr_hi;
            end
            `SPE_OP_PUT_IDENT: begin
              kind_ff <= spe_k_id_wr;
              state_ff <= spe_st_addr_hi;
            end
            `SPE_OP_GET_STATUS: state_ff <= spe_st_sout;
            `SPE_OP_PUT_STATUS: begin
              kind_ff <= spe_k_stat_wr;
              state_ff <= spe_st_sin;
            end
            `SPE_OP_ARM: begin
              kind_ff <= spe_k_arm;
              state_ff <= spe_st_armcmd;
            end
            `SPE_OP_DISARM: begin
              kind_ff <= spe_k_disarm;
              state_ff <= spe_st_armcmd;
            end
            default: state_ff <= spe_st_wait;
          endcase
        end
        spe_st_addr_hi: begin
          addr_ff[15:8] <= byte_val;
          state_ff <= spe_st_addr_lo;
        end
        spe_st_addr_lo: begin
          addr_ff[7:0] <= byte_val;
          cmd_addr_ff <= {addr_ff[15:8], byte_val};
          if (kind_ff == spe_k_arr_wr || kind_ff == spe_k_id_wr) begin
            state_ff <= spe_st_wdata;
          end else begin
            state_ff <= spe_st_rdout;
          end
        end
        spe_st_wdata: begin
          has_data_ff <= 1'b1;
          // Page writes wrap inside the page
          addr_ff[`SPE_PAGE_BITS-1:0] <= addr_ff[`SPE_PAGE_BITS-1:0] +
            7'h01;
        end
        spe_st_sin: begin
          if (!has_data_ff) begin
            sin_ff <= byte_val;
          end
          has_data_ff <= 1'b1;
        end
        spe_st_rdout: addr_ff <= addr_ff + 16'h0001;
        // An extra byte after arm or disarm parks in wait; the arm latch still acts on it
        spe_st_armcmd: state_ff <= spe_st_wait;
        default: begin
        end
      endcase
    end
  end

  // Transmit on falling clock; output off in wait and while paused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_ff <= `SPE_RST_BYTE;
      miso_ff <= 1'b0;
      oe_ff <= 1'b0;
    end else begin
      oe_ff <= active && (state_ff == spe_st_sout ||
                          state_ff == spe_st_rdout);
      if (active && sck_fall && (state_ff == spe_st_sout ||
                                 state_ff == spe_st_rdout)) begin
        if (bit_cnt_ff == `SPE_RST_CNT) begin
          if (state_ff == spe_st_sout) begin
            miso_ff <= status_byte[7];
            tx_ff <= {status_byte[6:0], 1'b0};
          end else begin
            miso_ff <= rd_data[7];
            tx_ff <= {rd_data[6:0], 1'b0};
          end
        end else begin
          miso_ff <= tx_ff[7];
          tx_ff <= {tx_ff[6:0], 1'b0};
        end
      end
    end
  end

  // Arm latch: arm opcode sets it, disarm and cycle end clear it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_ff <= 1'b0;
    end else if (deselect && !paused_ff && whole &&
                 kind_ff == spe_k_arm) begin
      arm_ff <= 1'b1;
    end else if (deselect && !paused_ff && whole &&
                 kind_ff == spe_k_disarm) begin
      arm_ff <= 1'b0;
    end else if (wdone) begin
      arm_ff <= 1'b0;
    end
  end

  // Nonvolatile bits: caught after reset, changed at status cycle end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nv_ff <= 3'h0;
      nv_load_ff <= 1'b1;
      pend_stat_ff <= 1'b0;
    end else begin
      nv_load_ff <= 1'b0;
      if (nv_load_ff) begin
        nv_ff <= nv_init;
      end else if (wdone && pend_stat_ff) begin
        nv_ff <= {sin_ff[`SPE_SB_LOCK], sin_ff[`SPE_SB_PHI],
                  sin_ff[`SPE_SB_PLO]};
      end
      if (start_w) begin
        pend_stat_ff <= (kind_ff == spe_k_stat_wr);
      end else if (wdone) begin
        pend_stat_ff <= 1'b0;
      end
    end
  end

  // Array staging strobes and the commit pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage_we_ff <= 1'b0;
      stage_addr_ff <= `SPE_RST_ADDR;
      stage_data_ff <= `SPE_RST_BYTE;
      commit_ff <= 1'b0;
      commit_kind_ff <= `SPE_CK_ARRAY;
      commit_addr_ff <= `SPE_RST_ADDR;
    end else begin
      stage_we_ff <= byte_done && state_ff == spe_st_wdata;
      if (byte_done && state_ff == spe_st_wdata) begin
        stage_addr_ff <= addr_ff;
        stage_data_ff <= byte_val;
      end
      commit_ff <= launch_arr;
      if (launch_arr) begin
        commit_addr_ff <= cmd_addr_ff;
        if (kind_ff == spe_k_arr_wr) begin
          commit_kind_ff <= `SPE_CK_ARRAY;
        end else if (cmd_addr_ff[`SPE_ID_LOCK_BIT]) begin
          commit_kind_ff <= `SPE_CK_IDLOCK;
        end else begin
          commit_kind_ff <= `SPE_CK_IDENT;
        end
      end
    end
  end

  // Outcome record for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_op_ff <= `SPE_RST_BYTE;
      last_ok_ff <= 1'b0;
      last_ref_ff <= 1'b0;
    end else if (deselect) begin
      last_op_ff <= opcode_ff;
      last_ok_ff <= start_w;
      last_ref_ff <= refuse;
    end
  end

  // APB slave: data caught in setup, one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcycle_ff <= TW_CYCLES[19:0];
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (psel && !penable) begin
      prdata_ff <= 32'h00000000;
      pslverr_ff <= 1'b0;
      case (paddr)
        `SPE_R_STATUS: prdata_ff <= {16'h0000, state_ff,
          armed_cs_ff, standby, paused_ff, selected, status_byte};
        `SPE_R_WCYCLE: prdata_ff <= {12'h000, wcycle_ff};
        `SPE_R_LASTCMD: prdata_ff <= {22'h000000, last_ref_ff,
          last_ok_ff, last_op_ff};
        `SPE_R_ADDR: prdata_ff <= {16'h0000, addr_ff};
        default: pslverr_ff <= 1'b1; // Unmapped
      endcase
    end else if (psel && penable && pwrite && paddr == `SPE_R_WCYCLE) begin
      wcycle_ff <= pwdata[19:0];
    end
  end

  assign pready = psel && penable;
  assign prdata = prdata_ff;
  assign pslverr = pslverr_ff && psel && penable;
  assign miso = miso_ff;
  assign miso_oe = oe_ff;
  assign rd_addr = addr_ff;
  assign rd_ident = (kind_ff == spe_k_id_rd);
  assign stage_we = stage_we_ff;
  assign stage_addr = stage_addr_ff;
  assign stage_data = stage_data_ff;
  assign commit = commit_ff;
  assign commit_kind = commit_kind_ff;
  assign commit_addr = commit_addr_ff;
  assign nv_bits = nv_ff;
endmodule

/* File: verification/spe_ctrl_monitor.sv */
// Port-level checker of the serial memory protocol front end
`timescale 1ns/1ps
module spe_ctrl_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic cs_n,
  input wire logic hold_n,
  input wire logic miso_oe,
  input wire logic commit,
  input wire logic standby
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] same_ff; // Cycles select kept its level
  logic [3:0] held_ff; // Cycles pause stayed low
  logic fell_ff; // A select fall was seen since reset
  logic cs_q_ff; // Select one cycle ago
  // Only aligned offsets below 0x10 are mapped
  wire mapped = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'h0);

  // Saturating level counters, so long idles stay meaningful
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      same_ff <= 4'h0;
      held_ff <= 4'h0;
      fell_ff <= 1'b0;
      cs_q_ff <= 1'b1;
    end else begin
      cs_q_ff <= cs_n;
      fell_ff <= fell_ff | (cs_q_ff & ~cs_n);
      if (cs_n != cs_q_ff) begin
        same_ff <= 4'h0;
      end else if (same_ff != 4'hf) begin
        same_ff <= same_ff + 4'h1;
      end
      held_ff <= hold_n ? 4'h0 : held_ff + {3'h0, held_ff != 4'hf};
    end
  end

  a_reset_state: assert property ($rose(presetn) |-> standby &&
    !miso_oe && !commit) else $error("state after reset wrong");
  a_ignore_early: assert property (!fell_ff |-> standby)
    else $error("selected before a select fall");
  a_oe_desel: assert property (cs_n && same_ff > 4'h6 |-> !miso_oe)
    else $error("output driven while deselected");
  a_active_sel: assert property
    (fell_ff && !cs_n && same_ff > 4'h6 |-> !standby)
    else $error("standby while selected");
  a_oe_pause: assert property (held_ff > 4'h6 |-> !miso_oe)
    else $error("output driven while paused");
  a_commit_busy: assert property (commit |=> !standby [*8])
    else $error("no busy after write launch");
  a_commit_desel: assert property (commit |-> cs_n && $past(cs_n))
    else $error("write launched while selected");
  a_unmapped_err: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong");
  c_commit: cover property (commit);
  c_paused: cover property (!cs_n && held_ff > 4'h6);
  c_driven: cover property (miso_oe);
endmodule

bind spe_ctrl spe_ctrl_monitor spe_ctrl_monitor_inst (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pslverr(pslverr), .cs_n(cs_n), .hold_n(hold_n), .miso_oe(miso_oe),
  .commit(commit), .standby(standby));

/* File: verification/spe_spi_master.sv */
// Serial bus master model, mode 0, 200 ns bit cell
`timescale 1ns/1ps
module spe_spi_master (
  output logic sck,
  output logic cs_n,
  output logic mosi,
  output logic hold_n,
  input wire logic miso
);
  logic [7:0] rx; // Bits taken back, newest last

  // Idle: deselected, clock low, not paused
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    hold_n = 1'b1;
  end

  // Low n bits of d, MSB first; read bit taken at the fall
  task automatic bits(input int n, input logic [7:0] d);
    for (int i = n - 1; i >= 0; i--) begin
      mosi = d[i];
      #100 sck = 1'b1;
      #100 rx = {rx[6:0], miso};
      sck = 1'b0;
    end
  endtask

  task automatic sel();
    #100 cs_n = 1'b0;
    #100;
  endtask

  // Raised after the last rise, with no further rise to follow
  task automatic desel();
    #50 cs_n = 1'b1;
    mosi = ~mosi; // Released line must not keep its last value
    #400;
  endtask

  // Pause changes only with clock low, with the device selected or not
  task automatic pause(input logic on);
    #50 hold_n = !on;
    #250;
  endtask
endmodule

/* File: verification/spe_ctrl_tb.sv */
// Self-checking bench of the serial memory protocol front end
`timescale 1ns/1ps
module spe_ctrl_tb;
  logic pclk, presetn, psel, penable, pwrite, wp_n, oe_seen, last_err;
  logic [7:0] paddr, rd_data, stage_data;
  logic [31:0] pwdata, prdata, q;
  logic pready, pslverr, sck, cs_n, mosi, hold_n, miso, miso_oe;
  logic [15:0] rd_addr, stage_addr, commit_addr, c_addr;
  logic rd_ident, stage_we, commit, standby;
  logic [1:0] commit_kind;
  logic [2:0] nv_bits, nv_init;
  int n_errors, total_checks, n_commit, cyc;
  assign rd_data = rd_addr[7:0] ^ 8'ha5; // Array stand-in

  spe_ctrl #(.TW_CYCLES(20)) spe_ctrl_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n), .wp_n(wp_n),
    .miso(miso), .miso_oe(miso_oe), .nv_init(nv_init), .rd_addr(rd_addr),
    .rd_ident(rd_ident), .rd_data(rd_data), .stage_we(stage_we),
    .stage_addr(stage_addr), .stage_data(stage_data), .commit(commit),
    .commit_kind(commit_kind), .commit_addr(commit_addr),
    .nv_bits(nv_bits), .standby(standby));
  spe_spi_master m (.sck(sck), .cs_n(cs_n), .mosi(mosi), .hold_n(hold_n),
    .miso(miso));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Watchers: launches, driven output, and the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (miso_oe === 1'b1) oe_seen = 1'b1;
    if (commit === 1'b1) begin
      n_commit++;
      c_addr = commit_addr;
    end
    if (cyc == 40000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmd(input logic [7:0] op);
    m.sel();
    m.bits(8, op);
    m.desel();
  endtask

  // Array write command with a number of stray extra clocks
  task automatic wr(input logic [15:0] a, input int extra);
    m.sel();
    m.bits(8, 8'h02);
    m.bits(8, a[15:8]);
    m.bits(8, a[7:0]);
    m.bits(8, 8'h3c);
    if (extra > 0) m.bits(extra, 8'hff);
    m.desel();
  endtask

  task automatic t_reset();
    apb(1'b0, 8'h00, 32'h0);
    check(q[11:0], 12'h484);
    apb(1'b1, 8'h04, 32'h18);
    apb(1'b0, 8'h04, 32'h0);
    check(q[19:0], 20'h18);
    apb(1'b0, 8'h10, 32'h0);
    check(last_err, 1'b1);
  endtask

  task automatic t_status();
    cmd(8'h06);
    apb(1'b0, 8'h00, 32'h0);
    check(q[11:0], 12'hc86);
    m.sel();
    m.bits(8, 8'h05);
    m.bits(8, 8'h00);
    m.desel();
    check(m.rx, 8'h86);
    // Ident read: array stand-in answers address xor a5
    m.sel();
    m.bits(8, 8'h83);
    m.bits(8, 8'h00);
    m.bits(8, 8'h12);
    m.bits(8, 8'h00);
    check(rd_ident, 1'b1);
    m.desel();
    check(m.rx, 8'hb7);
  endtask

  task automatic t_ops();
    logic [7:0] ops [8];
    ops = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03, 8'h02, 8'h83, 8'h82};
    foreach (ops[i]) begin
      cmd(ops[i]);
      apb(1'b0, 8'h08, 32'h0);
      check(q[7:0], ops[i]);
    end
    apb(1'b0, 8'h00, 32'h0);
    check(q[7:0], 8'h84);
    check(n_commit, 0);
  endtask

  // Unknown opcode: later arm byte ignored, output never driven
  task automatic t_unknown();
    oe_seen = 1'b0;
    m.sel();
    m.bits(8, 8'h5a);
    m.bits(8, 8'h06);
    m.desel();
    check(oe_seen, 1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check(q[1], 1'b0);
  endtask

  task automatic t_write();
    wr(16'h0010, 0);
    check(n_commit, 0);
    cmd(8'h06);
    wr(16'hc000, 0);
    wr(16'h0010, 3);
    apb(1'b0, 8'h08, 32'h0);
    check(q[9], 1'b1);
    check(n_commit, 0);
    wr(16'hbfff, 0);
    check({n_commit, c_addr}, {32'h1, 16'hbfff});
    check({commit_kind, stage_addr, stage_data}, {2'h0, 16'hbfff, 8'h3c});
    apb(1'b0, 8'h00, 32'h0);
    check(q[1:0], 2'h3);
    repeat (40) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    check(q[7:0], 8'h84);
    @(posedge pclk) wp_n <= 1'b0;
    cmd(8'h06);
    m.sel();
    m.bits(8, 8'h01);
    m.bits(8, 8'h0c);
    m.desel();
    // Wait past a full write cycle so a wrongly started one would show
    repeat (40) @(posedge pclk);
    check(nv_bits, 3'h5);
    @(posedge pclk) wp_n <= 1'b1;
  endtask

  task automatic t_pause();
    m.sel();
    m.bits(8, 8'h02);
    m.bits(8, 8'h00);
    m.pause(1'b1);
    m.bits(8, 8'hff);
    apb(1'b0, 8'h00, 32'h0);
    check(q[9], 1'b1);
    m.pause(1'b0);
    m.bits(8, 8'h10);
    m.bits(8, 8'h3c);
    m.desel();
    check({n_commit, c_addr}, {32'h2, 16'h0010});
    repeat (40) @(posedge pclk);
    cmd(8'h06);
    m.sel();
    m.bits(8, 8'h02);
    m.bits(8, 8'h00);
    m.bits(8, 8'h20);
    m.bits(8, 8'h3c);
    m.pause(1'b1);
    m.desel();
    m.pause(1'b0);
    check({n_commit, c_addr}, {32'h3, 16'h0020});
    repeat (40) @(posedge pclk);
    cmd(8'h06);
    m.sel();
    m.bits(8, 8'h02);
    m.pause(1'b1);
    m.desel();
    m.pause(1'b0);
    apb(1'b0, 8'h00, 32'h0);
    check({n_commit, q[7:0]}, {32'h3, 8'h86});
  endtask

  // Reset in mid-run: arm clears, stored bits are caught afresh
  task automatic t_rerun();
    @(posedge pclk) presetn <= 1'b0;
    nv_init <= 3'h2;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h00, 32'h0);
    check(q[11:0], 12'h408);
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wp_n = 1'b1;
    nv_init = 3'h5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_status();
    t_ops();
    t_unknown();
    t_write();
    t_pause();
    t_rerun();
    summarize();
  end
endmodule
